// ### hdl/pmu_pkg.sv
/*
  Constants, register map and types for the power and clock gate control unit.
  Assumes a 32-bit APB slave port with a 12-bit byte address window.
*/
package pmu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFF_LOW_POWER_CONTROL = 12'h004;
  localparam logic [11:0] OFF_PERIPHERAL_CLOCK_GATE = 12'h020;
  localparam logic [11:0] OFF_OSCILLATOR_POWER_CONTROL = 12'h024;
  localparam logic [11:0] OFF_SWITCH_CHAIN0_START_TIME = 12'h090;
  localparam logic [11:0] OFF_SWITCH_CHAIN1_START_TIME = 12'h094;
  localparam logic [11:0] OFF_SWITCH_CHAIN2_START_TIME = 12'h098;
  localparam logic [11:0] OFF_SWITCH_CHAIN3_START_TIME = 12'h09c;
  localparam logic [11:0] OFF_SOFT_RESET_BUS_CONTROL = 12'h0c4;
  localparam logic [11:0] OFF_SLEEP_BOOT_CONTROL = 12'h0c8;
  localparam logic [11:0] OFF_SLEEP_RESUME_PC = 12'h0cc;
  localparam logic [11:0] OFF_ASYNC_HANDSHAKE_CONTROL = 12'h0ec;
  localparam logic [11:0] OFF_PMU_STATUS = 12'h0f0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_LOW_POWER_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_PERIPHERAL_CLOCK_GATE = 32'h1fff_ff80;
  localparam logic [31:0] RST_OSCILLATOR_POWER_CONTROL = 32'h1080_1500;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int LPM_LSB = 0;
  localparam int LPM_W = 2;
  localparam int PST_LSB = 8;
  localparam int PST_W = 12;
  localparam int CHAIN_W = 16;
  localparam int TIMER_W = 16;
  localparam logic [1:0] LPM_IDLE = 2'h0;
  localparam logic [1:0] LPM_SLEEP = 2'h1;
  localparam int GATE_DRAM = 31;
  localparam int GATE_CPU_KEEP = 30;
  localparam int GATE_AHB = 29;
  localparam int GATE_APB = 28;
  localparam logic [3:0] FULL_WORD_STRB = 4'hf;

  typedef enum {st_run, st_idle, st_sleep, st_stabilize, st_chain_wait} lp_state_t;

endpackage

// ### hdl/wait_timer_if.sv
/*
  Handshake between the low-power sequencer and its wait timer.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface wait_timer_if;
  import pmu_pkg::*;
  logic start;
  logic use_rtc;
  logic [TIMER_W-1:0] count;
  logic done;
  modport ctrl (output start, use_rtc, count, input done);
  modport timer (input start, use_rtc, count, output done);
endinterface
`default_nettype wire

// ### hdl/rtc_tick_sync.sv
/*
  Brings the slow realtime clock pin into pclk and marks each rising edge.
  Assumes pclk is much faster than the slow clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_tick_sync (
  input wire logic pclk,        // bus clock
  input wire logic presetn,     // async reset, active low
  input wire logic ce,          // clock enable
  input wire logic rtc_clk_pin, // slow realtime clock pin
  output logic tick             // one-cycle pulse per slow rising edge
);
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      tick <= 1'b0;
    end else if (ce) begin
      sync1_q <= rtc_clk_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      tick <= sync2_q & ~sync3_q;
    end
  end
endmodule
`default_nettype wire

// ### hdl/wait_timer.sv
/*
  Down counter that times a wait in pclk cycles or in slow clock ticks.
  Assumes start is a one-cycle pulse and is not raised while busy.
*/
`timescale 1ns/1ns
`default_nettype none
module wait_timer
  import pmu_pkg::*;
(
  input wire logic pclk,       // bus clock
  input wire logic presetn,    // async reset, active low
  input wire logic ce,         // clock enable
  input wire logic rtc_tick,   // slow clock tick
  wait_timer_if.timer tif      // sequencer side
);
  logic [TIMER_W-1:0] remaining_q;
  logic busy_q;
  logic rtc_q;
  logic done_q;

  assign tif.done = done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining_q <= '0;
      busy_q <= 1'b0;
      rtc_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (tif.start) begin
        remaining_q <= tif.count;
        rtc_q <= tif.use_rtc;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (remaining_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else if (!rtc_q || rtc_tick) begin
          remaining_q <= remaining_q - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/power_clock_gate_control.sv
/*
  Power and clock gate control unit: APB register file, low-power sequencer,
  per-peripheral clock enables and access blocks.
  Assumes pclk itself stays running while the chip sleeps, that the core sends
  a one-cycle pulse on pclk when its sleep instruction retires, and that the
  wake interrupt is a level from logic on pclk.
*/
// Decided for this implementation: the APB register port.
// Contract
// - Registers take only full 32-bit word accesses at their byte addresses.
// - The low power control register is all zeros after any reset.
// - Mode field value 00 makes the sleep instruction enter idle, 01 enters sleep.
// - The power stability field is a wait counted in slow realtime clock cycles.
// - Each switch chain start time is a wait counted in pclk cycles.
// - A set gate bit stops that peripheral's clock and blocks its register access.
// - Each gate bit comes out of reset at its documented start value.
// - Gate bit 30 keeps the core clock running through power down instead of gating a peripheral.
// - Gate bits 31, 29 and 28 stop the DRAM controller, main AHB and APB clocks like any other.
// - Idle stops only the core clock and any interrupt ends it.
// - Sleep stops the PLL and every clock except a core clock kept by bit 30, and ends on reset or interrupt.
`timescale 1ns/1ns
`default_nettype none
module power_clock_gate_control
  import pmu_pkg::*;
(
  input wire logic pclk,                       // bus clock
  input wire logic presetn,                    // async reset, active low
  input wire logic ce,                         // clock enable, freezes all state
  input wire logic [11:0] paddr,               // APB byte address
  input wire logic psel,                       // APB select
  input wire logic penable,                    // APB access phase
  input wire logic pwrite,                     // APB write
  input wire logic [31:0] pwdata,              // APB write data
  input wire logic [3:0] pstrb,                // APB byte strobes
  output logic [31:0] prdata,                  // APB read data
  output logic pready,                         // APB ready
  output logic pslverr,                        // APB error
  input wire logic sleep_retire,               // core pulse: sleep instruction retired
  input wire logic wake_irq,                   // any pending interrupt
  input wire logic rtc_clk_pin,                // slow realtime clock pin
  output logic [31:0] periph_clk_en,           // clock enables per peripheral
  output logic [31:0] periph_access_block,     // register access blocked per peripheral
  output logic core_clk_en,                    // core clock enable
  output logic pll_en,                         // PLL enable
  output logic [3:0] chain_power_on,           // power switch chains on
  output logic lp_idle,                        // idle mode active
  output logic lp_sleep                        // sleep or wake sequence active
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic reg_hit(input logic [11:0] a);
    case (a)
      OFF_LOW_POWER_CONTROL, OFF_PERIPHERAL_CLOCK_GATE,
      OFF_OSCILLATOR_POWER_CONTROL, OFF_SWITCH_CHAIN0_START_TIME,
      OFF_SWITCH_CHAIN1_START_TIME, OFF_SWITCH_CHAIN2_START_TIME,
      OFF_SWITCH_CHAIN3_START_TIME, OFF_SOFT_RESET_BUS_CONTROL,
      OFF_SLEEP_BOOT_CONTROL, OFF_SLEEP_RESUME_PC,
      OFF_ASYNC_HANDSHAKE_CONTROL, OFF_PMU_STATUS: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] state_code(input lp_state_t s);
    case (s)
      st_run: state_code = 3'h0;
      st_idle: state_code = 3'h1;
      st_sleep: state_code = 3'h2;
      st_stabilize: state_code = 3'h3;
      st_chain_wait: state_code = 3'h4;
      default: state_code = 3'h7;
    endcase
  endfunction

  // Bit 30 is a core control, not a peripheral; it never gates anything itself
  function automatic logic [31:0] gate_mask(input logic [31:0] g);
    logic [31:0] m;
    m = g;
    m[GATE_CPU_KEEP] = 1'b0;
    gate_mask = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [LPM_W-1:0] lpm_q;
  logic [PST_W-1:0] pst_q;
  logic [31:0] gate_q;
  logic [31:0] osc_q;
  logic [CHAIN_W-1:0] chain_time_q [4];
  logic [31:0] soft_reset_bus_control_q;
  logic [31:0] sleep_boot_control_q;
  logic [31:0] sleep_resume_pc_q;
  logic [31:0] hsk_q;

  lp_state_t state_q;
  logic [1:0] chain_idx_q;

  logic setup_phase;
  logic access_done;
  logic bad_access;
  logic wr_ok;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign bad_access = ~reg_hit(paddr) | (pwrite & (pstrb != FULL_WORD_STRB));
  assign wr_ok = access_done & pwrite & ~pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: no wait states, answer registered at setup

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup_phase) begin
        pready <= 1'b1;
        pslverr <= bad_access;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RST_ZERO;
    end else if (ce) begin
      if (setup_phase && !pwrite) begin
        case (paddr)
          OFF_LOW_POWER_CONTROL: prdata <= {12'h000, pst_q, 6'h00, lpm_q};
          OFF_PERIPHERAL_CLOCK_GATE: prdata <= gate_q;
          OFF_OSCILLATOR_POWER_CONTROL: prdata <= osc_q;
          OFF_SWITCH_CHAIN0_START_TIME: prdata <= {16'h0000, chain_time_q[0]};
          OFF_SWITCH_CHAIN1_START_TIME: prdata <= {16'h0000, chain_time_q[1]};
          OFF_SWITCH_CHAIN2_START_TIME: prdata <= {16'h0000, chain_time_q[2]};
          OFF_SWITCH_CHAIN3_START_TIME: prdata <= {16'h0000, chain_time_q[3]};
          OFF_SOFT_RESET_BUS_CONTROL: prdata <= soft_reset_bus_control_q;
          OFF_SLEEP_BOOT_CONTROL: prdata <= sleep_boot_control_q;
          OFF_SLEEP_RESUME_PC: prdata <= sleep_resume_pc_q;
          OFF_ASYNC_HANDSHAKE_CONTROL: prdata <= hsk_q;
          OFF_PMU_STATUS: prdata <= {21'h000000, chain_idx_q, chain_power_on,
                                     pll_en, core_clk_en, state_code(state_q)};
          default: prdata <= RST_ZERO;
        endcase
      end else if (access_done) begin
        prdata <= RST_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low power control

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpm_q <= RST_LOW_POWER_CONTROL[LPM_LSB +: LPM_W];
      pst_q <= RST_LOW_POWER_CONTROL[PST_LSB +: PST_W];
    end else if (ce) begin
      if (wr_ok && paddr == OFF_LOW_POWER_CONTROL) begin
        lpm_q <= pwdata[LPM_LSB +: LPM_W];
        pst_q <= pwdata[PST_LSB +: PST_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gate register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= RST_PERIPHERAL_CLOCK_GATE;
    end else if (ce) begin
      if (wr_ok && paddr == OFF_PERIPHERAL_CLOCK_GATE) begin
        gate_q <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch chain start times

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        chain_time_q[i] <= RST_ZERO[CHAIN_W-1:0];
      end
    end else if (ce) begin
      if (wr_ok) begin
        case (paddr)
          OFF_SWITCH_CHAIN0_START_TIME: chain_time_q[0] <= pwdata[CHAIN_W-1:0];
          OFF_SWITCH_CHAIN1_START_TIME: chain_time_q[1] <= pwdata[CHAIN_W-1:0];
          OFF_SWITCH_CHAIN2_START_TIME: chain_time_q[2] <= pwdata[CHAIN_W-1:0];
          OFF_SWITCH_CHAIN3_START_TIME: chain_time_q[3] <= pwdata[CHAIN_W-1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain storage registers; their fields drive no logic here and are only read back over APB

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= RST_OSCILLATOR_POWER_CONTROL;
      soft_reset_bus_control_q <= RST_ZERO;
      sleep_boot_control_q <= RST_ZERO;
      sleep_resume_pc_q <= RST_ZERO;
      hsk_q <= RST_ZERO;
    end else if (ce) begin
      if (wr_ok) begin
        case (paddr)
          OFF_OSCILLATOR_POWER_CONTROL: osc_q <= pwdata;
          OFF_SOFT_RESET_BUS_CONTROL: soft_reset_bus_control_q <= pwdata;
          OFF_SLEEP_BOOT_CONTROL: sleep_boot_control_q <= pwdata;
          OFF_SLEEP_RESUME_PC: sleep_resume_pc_q <= pwdata;
          OFF_ASYNC_HANDSHAKE_CONTROL: hsk_q <= pwdata;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait timer and slow clock

  logic rtc_tick;
  wait_timer_if tif ();

  rtc_tick_sync u_rtc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rtc_clk_pin(rtc_clk_pin),
    .tick(rtc_tick)
  );

  wait_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rtc_tick(rtc_tick),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Low power sequencer

  logic start_q;
  logic use_rtc_q;
  logic [TIMER_W-1:0] count_q;

  assign tif.start = start_q;
  assign tif.use_rtc = use_rtc_q;
  assign tif.count = count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_run;
      chain_idx_q <= 2'h0;
      start_q <= 1'b0;
      use_rtc_q <= 1'b0;
      count_q <= '0;
    end else if (ce) begin
      start_q <= 1'b0;
      case (state_q)
        st_run: begin
          if (sleep_retire) begin
            if (lpm_q == LPM_IDLE) begin
              state_q <= st_idle;
            end else if (lpm_q == LPM_SLEEP) begin
              state_q <= st_sleep;
            end
          end
        end
        st_idle: begin
          if (wake_irq) begin
            state_q <= st_run;
          end
        end
        st_sleep: begin
          if (wake_irq) begin
            state_q <= st_stabilize;
            start_q <= 1'b1;
            use_rtc_q <= 1'b1;
            count_q <= {{(TIMER_W-PST_W){1'b0}}, pst_q};
          end
        end
        st_stabilize: begin
          if (tif.done) begin
            state_q <= st_chain_wait;
            chain_idx_q <= 2'h0;
            start_q <= 1'b1;
            use_rtc_q <= 1'b0;
            count_q <= chain_time_q[0];
          end
        end
        st_chain_wait: begin
          if (tif.done) begin
            if (chain_idx_q == 2'h3) begin
              state_q <= st_run;
            end else begin
              chain_idx_q <= chain_idx_q + 2'h1;
              start_q <= 1'b1;
              use_rtc_q <= 1'b0;
              count_q <= chain_time_q[chain_idx_q + 2'h1];
            end
          end
        end
        default: state_q <= st_run;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power switch chains: dropped on sleep entry, raised one by one on wake

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_power_on <= 4'hf;
    end else if (ce) begin
      if (state_q == st_run && sleep_retire && lpm_q == LPM_SLEEP) begin
        chain_power_on <= 4'h0;
      end else if (state_q == st_chain_wait && tif.done) begin
        chain_power_on[chain_idx_q] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables, registered from the next state view

  lp_state_t state_nx;
  always_comb begin
    state_nx = state_q;
    case (state_q)
      st_run: begin
        if (sleep_retire && lpm_q == LPM_IDLE) state_nx = st_idle;
        else if (sleep_retire && lpm_q == LPM_SLEEP) state_nx = st_sleep;
      end
      st_idle: if (wake_irq) state_nx = st_run;
      st_sleep: if (wake_irq) state_nx = st_stabilize;
      st_stabilize: if (tif.done) state_nx = st_chain_wait;
      st_chain_wait: if (tif.done && chain_idx_q == 2'h3) state_nx = st_run;
      default: state_nx = st_run;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= ~gate_mask(RST_PERIPHERAL_CLOCK_GATE);
      periph_access_block <= gate_mask(RST_PERIPHERAL_CLOCK_GATE);
      core_clk_en <= 1'b1;
      pll_en <= 1'b1;
      lp_idle <= 1'b0;
      lp_sleep <= 1'b0;
    end else if (ce) begin
      periph_access_block <= gate_mask(gate_q);
      lp_idle <= (state_nx == st_idle);
      lp_sleep <= (state_nx != st_run) && (state_nx != st_idle);
      case (state_nx)
        st_run: begin
          periph_clk_en <= ~gate_mask(gate_q);
          core_clk_en <= 1'b1;
          pll_en <= 1'b1;
        end
        st_idle: begin
          periph_clk_en <= ~gate_mask(gate_q);
          core_clk_en <= 1'b0;
          pll_en <= 1'b1;
        end
        st_sleep: begin
          periph_clk_en <= 32'h0000_0000;
          core_clk_en <= gate_q[GATE_CPU_KEEP];
          pll_en <= 1'b0;
        end
        default: begin
          // PLL relocking and chains ramping: peripheral clocks stay off until done
          periph_clk_en <= 32'h0000_0000;
          core_clk_en <= gate_q[GATE_CPU_KEEP];
          pll_en <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### sim/pmu_checker.sv
/*
  Port checker for the power and clock gate control unit.
  Assumes one pclk domain; bound in from the bench top file.
*/
`timescale 1ns/1ns
`default_nettype none
module pmu_checker
  import pmu_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic wake_irq, // wake level
  input wire logic [31:0] periph_clk_en, // peripheral enables
  input wire logic [31:0] periph_access_block, // access blocks
  input wire logic core_clk_en, // core enable
  input wire logic pll_en, // PLL enable
  input wire logic [3:0] chain_power_on, // chains on
  input wire logic lp_idle, // idle active
  input wire logic lp_sleep // sleep active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  property p_ready;
    (psel && !penable && ce) ##1 ce |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("pready held two cycles");
  property p_narrow;
    (psel && !penable && ce && pwrite && pstrb != 4'hf) ##1 ce |-> pslverr;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow write not refused");
  property p_rdz;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_split;
    !lp_sleep |-> periph_clk_en == ~periph_access_block && !periph_access_block[30];
  endproperty
  a_split: assert property (p_split) else $error("enable and block disagree");
  property p_sleep_off;
    lp_sleep |-> periph_clk_en == 32'h0 && !lp_idle;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("clock running in sleep");
  property p_pll;
    !lp_sleep |-> pll_en;
  endproperty
  a_pll: assert property (p_pll) else $error("PLL off outside sleep");
  property p_idle;
    lp_idle |-> !core_clk_en && pll_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle core clock wrong");
  property p_wake;
    lp_idle && wake_irq && ce |=> !lp_idle && core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("idle not ended by interrupt");
  property p_enter;
    $rose(lp_sleep) |-> chain_power_on == 4'h0 && !pll_en;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep entry state wrong");
  property p_leave;
    $fell(lp_sleep) |-> chain_power_on == 4'hf && pll_en;
  endproperty
  a_leave: assert property (p_leave) else $error("wake end state wrong");
  c_idle: cover property ($rose(lp_idle));
  c_sleep: cover property ($fell(lp_sleep));
  c_err: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ### sim/testbench.sv
/*
  Bench for the power and clock gate control unit: APB master tasks, core
  pulses, wake level and a free-running slow clock, driven at pclk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pmu_pkg::*;
;
  logic pclk = 0;
  logic presetn = 0;
  logic ce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic sleep_retire = 0;
  logic wake_irq = 0;
  logic rtc_clk_pin = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, periph_clk_en, periph_access_block;
  logic [3:0] chain_power_on;
  logic pready, pslverr, core_clk_en, pll_en, lp_idle, lp_sleep;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, k;
  int rise[4];
  logic [11:0] ra[12] = '{12'h004, 12'h020, 12'h024, 12'h090, 12'h094, 12'h098, 12'h09c,
    12'h0c4, 12'h0c8, 12'h0cc, 12'h0ec, 12'h0f0};
  logic [31:0] rv[12] = '{32'h0, 32'h1fffff80, 32'h10801500, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h1f8};
  logic [31:0] wm[12] = '{32'h000fff03, 32'hffffffff, 32'h0, 32'hffff, 32'hffff, 32'hffff, 32'hffff,
    32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h1f8};

  always #25 pclk = ~pclk;
  // Slow clock of 20 pclk periods keeps stabilize waits short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 9)
      rtc_clk_pin <= ~rtc_clk_pin;
  end

  power_clock_gate_control dut (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sleep_retire, .wake_irq, .rtc_clk_pin, .periph_clk_en,
    .periph_access_block, .core_clk_en, .pll_en, .chain_power_on, .lp_idle, .lp_sleep);

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int v, input int lo, input int hi);
    chk(what, 32'h1, {31'h0, v >= lo && v <= hi});
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [31:0] xq, input logic xe);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
    if (!w)
      chk("prdata", xq, prdata);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic outs(input logic [31:0] en, input logic [31:0] blk, input logic [7:0] m);
    repeat (2) @(posedge pclk);
    #1;
    chk("periph_clk_en", en, periph_clk_en);
    chk("periph_access_block", blk, periph_access_block);
    chk("core_pll_chain_idle_sleep", {24'h0, m}, {24'h0, core_clk_en, pll_en, chain_power_on, lp_idle, lp_sleep});
    @(posedge pclk);
  endtask
  task automatic retire;
    sleep_retire <= 1;
    @(posedge pclk);
    sleep_retire <= 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    outs(32'he000007f, 32'h1fffff80, 8'hfc);
    for (int i = 0; i < 12; i++) xfer(0, ra[i], 32'h0, 4'hf, rv[i], 0);
    for (int i = 0; i < 12; i++) if (i != 2) xfer(1, ra[i], 32'hffffffff, 4'hf, 32'h0, 0);
    for (int i = 0; i < 12; i++) if (i != 2) xfer(0, ra[i], 32'h0, 4'hf, wm[i], 0);
    outs(32'h40000000, 32'hbfffffff, 8'hfc);
    xfer(1, 12'h004, 32'h0, 4'h3, 32'h0, 1);
    xfer(0, 12'h004, 32'h0, 4'hf, 32'h000fff03, 0);
    xfer(0, 12'h100, 32'h0, 4'hf, 32'h0, 1);
    xfer(1, 12'h0f8, 32'h1, 4'hf, 32'h0, 1);
    xfer(1, 12'h020, 32'hb00000f0, 4'hf, 32'h0, 0);
    outs(32'h4fffff0f, 32'hb00000f0, 8'hfc);
    xfer(1, 12'h020, 32'h000000f0, 4'hf, 32'h0, 0);
    xfer(1, 12'h004, 32'h00000200, 4'hf, 32'h0, 0);
    retire();
    outs(32'hffffff0f, 32'h000000f0, 8'h7e);
    xfer(0, 12'h004, 32'h0, 4'hf, 32'h00000200, 0);
    // Clock enable low: the interrupt must not end idle until it returns
    ce <= 0;
    wake_irq <= 1;
    outs(32'hffffff0f, 32'h000000f0, 8'h7e);
    ce <= 1;
    @(posedge pclk);
    wake_irq <= 0;
    outs(32'hffffff0f, 32'h000000f0, 8'hfc);
    xfer(1, 12'h004, 32'h00000202, 4'hf, 32'h0, 0);
    retire();
    outs(32'hffffff0f, 32'h000000f0, 8'hfc);
    xfer(1, 12'h020, 32'h400000f0, 4'hf, 32'h0, 0);
    xfer(1, 12'h090, 32'd3, 4'hf, 32'h0, 0);
    xfer(1, 12'h094, 32'd0, 4'hf, 32'h0, 0);
    xfer(1, 12'h098, 32'd9, 4'hf, 32'h0, 0);
    xfer(1, 12'h09c, 32'd1, 4'hf, 32'h0, 0);
    xfer(1, 12'h004, 32'h00000201, 4'hf, 32'h0, 0);
    retire();
    outs(32'h0, 32'h000000f0, 8'h81);
    wake_irq <= 1;
    t0 = cyc;
    @(posedge pclk);
    wake_irq <= 0;
    rise = '{0, 0, 0, 0};
    for (k = 0; k < 3000 && lp_sleep !== 1'b0; k++) begin
      @(posedge pclk);
      for (int j = 0; j < 4; j++)
        if (chain_power_on[j] === 1'b1 && rise[j] == 0)
          rise[j] = cyc;
    end
    if (k == 3000) begin
      num_errors++;
      stop_test();
    end
    // Two slow edges after the load (21 to 40 cycles) plus 11 of load and chain 0
    rng("stabilize_wait", rise[0] - t0, 32, 51);
    rng("chain1_wait", rise[1] - rise[0], 1, 3);
    rng("chain2_wait", rise[2] - rise[1], 10, 12);
    rng("chain3_wait", rise[3] - rise[2], 2, 4);
    outs(32'hffffff0f, 32'h000000f0, 8'hfc);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 12'h004, 32'h0, 4'hf, 32'h0, 0);
    xfer(0, 12'h020, 32'h0, 4'hf, 32'h1fffff80, 0);
    stop_test();
  end
endmodule

bind power_clock_gate_control pmu_checker chk_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .pstrb,
  .prdata, .pready, .pslverr, .wake_irq, .periph_clk_en, .periph_access_block, .core_clk_en, .pll_en,
  .chain_power_on, .lp_idle, .lp_sleep);
`default_nettype wire
